// ===== rtl/pmrc_defines.svh
/*
 power-mode and reset control: register offsets, codes and field positions.
 assumes inclusion by bare name from rtl/.
*/
`ifndef PMRC_DEFINES_SVH
`define PMRC_DEFINES_SVH
// power mode register is kept as a word index; its byte address is four times it
`define PMRC_IDX_PWR_MODE 10'h087
`define PMRC_OFF_WAKE_EN 12'h100
`define PMRC_OFF_CLK_CFG 12'h104
`define PMRC_OFF_RST_CFG 12'h108
`define PMRC_OFF_STATUS 12'h10c
`define PMRC_OFF_CPU_INIT 12'h110
`define PMRC_CODE_IDLE 8'h01
`define PMRC_CODE_STOP 8'h03
`define PMRC_PC_RESET 16'h0000
`define PMRC_ACC_RESET 8'h00
`define PMRC_SP_RESET 8'h07
`define PMRC_NUM_WAKE 7
`define PMRC_NUM_RST 5
`define PMRC_RST_EXT 0
`define PMRC_RST_POR 1
`define PMRC_RST_WDT 2
`define PMRC_RST_LVR 3
`define PMRC_RST_DBG 4
`define PMRC_CLK_IRC 2'h0
`define PMRC_CLK_MAIN 2'h1
`define PMRC_CLK_SUB 2'h2
`define PMRC_STAB_DEF 16'h0010
`endif

// ===== rtl/pmrc_pkg.sv
/*
 power-mode and reset control: shared types.
 assumes the defines header is compiled with it.
*/
package pmrc_pkg;
    typedef enum logic [1:0] {
        PMRC_RUN = 2'h0,
        PMRC_IDLE = 2'h1,
        PMRC_STOP = 2'h3,
        PMRC_STAB = 2'h2
    } pmrc_state_e;
endpackage

// ===== rtl/pmrc_sync.sv
/*
 pmrc_sync: two-flop synchroniser for a vector of asynchronous levels.
 assumes the destination clock is pclk; the first stage feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none
module pmrc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/pmrc_top.sv
/*
 pmrc_top: power-mode controller (run, idle, stop, stabilisation) with reset-source
 gathering, reached over apb. assumes the cpu core obeys cpu_halt, the clock tree
 obeys the gate outputs, and the interval timer reports its overflow as a pulse.
*/
// Notes on behaviour
// - code 01h enters idle; codes other than 01h and 03h stay running
// - code 03h enters stop
// - release clears the power mode register
// - idle halts cpu, clocks keep running
// - idle leaves on reset or any interrupt whose wake enable bit is set
// - stop halts oscillator, system, peripheral clocks
// - stop leaves only on reset or interrupt
// - stop wake starts interval timer stabilisation
// - global enable set: wake and vector
// - global enable clear still wakes stop
// - stop halts timers except event counters
// - stop serial units run on external clock
// - stop wake sources are a limited set
// - oscillator stops only if system source
// - reset loads pc, acc, sp; clock on
// - five reset sources; only watchdog and low voltage have enable qualifiers
`timescale 1ns/1ps
`default_nettype none
`include "pmrc_defines.svh"
module pmrc_top import pmrc_pkg::*; #(
    parameter int NWAKE = `PMRC_NUM_WAKE,
    parameter int NTIMER = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NWAKE-1:0] irq_pending,
    input wire logic global_interrupt_enable,
    input wire logic bit_overflow,
    input wire logic external_reset_pin_n,
    input wire logic power_on_reset,
    input wire logic watchdog_overflow,
    input wire logic watchdog_enable_bit,
    input wire logic low_voltage_reset,
    input wire logic low_voltage_reset_control_bit,
    input wire logic debug_reset,
    input wire logic [NTIMER-1:0] timer_event_mode,
    input wire logic [1:0] serial_ext_clock,
    output logic cpu_halt,
    output logic cpu_vector_req,
    output logic bit_start,
    output logic sys_clk_en,
    output logic periph_clk_en,
    output logic irc_osc_en,
    output logic main_osc_en,
    output logic sub_osc_en,
    output logic [NTIMER-1:0] timer_clk_en,
    output logic [1:0] serial_clk_en,
    output logic core_reset,
    output logic [15:0] pc_init,
    output logic [7:0] acc_init,
    output logic [7:0] sp_init
);
    logic [7:0] power_mode_control_reg;
    logic [7:0] power_mode_control_next;
    logic [NWAKE-1:0] wake_enable_reg;
    logic [1:0] clk_src_reg;
    logic [1:0] rst_cfg_reg;
    logic [15:0] stab_limit_reg;
    logic [15:0] stab_cnt_reg;
    logic [`PMRC_NUM_RST-1:0] rst_flags_reg;
    pmrc_state_e state_reg;
    pmrc_state_e state_next;
    logic [31:0] rdata_next;
    logic [4:0] rst_raw;
    logic [4:0] rst_sync;

    // pin-side reset requests are asynchronous to pclk
    assign rst_raw = {debug_reset, low_voltage_reset, watchdog_overflow,
                      power_on_reset, ~external_reset_pin_n};
    pmrc_sync #(.WIDTH(5)) u_rst_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(rst_raw),
        .sync_out(rst_sync)
    );

    wire [`PMRC_NUM_RST-1:0] rst_qual;
    assign rst_qual[`PMRC_RST_EXT] = rst_sync[`PMRC_RST_EXT];
    assign rst_qual[`PMRC_RST_POR] = rst_sync[`PMRC_RST_POR];
    assign rst_qual[`PMRC_RST_WDT] = rst_sync[`PMRC_RST_WDT] & watchdog_enable_bit;
    assign rst_qual[`PMRC_RST_LVR] = rst_sync[`PMRC_RST_LVR] & ~low_voltage_reset_control_bit;
    assign rst_qual[`PMRC_RST_DBG] = rst_sync[`PMRC_RST_DBG];
    wire any_reset = |rst_qual;

    // wake sources: irq_pending already restricted by the irq map to stop-capable ones in stop
    wire [NWAKE-1:0] wake_hits = irq_pending & wake_enable_reg;
    wire any_wake = |wake_hits;

    // one compare shape for every register select
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] offset);
        return addr == offset;
    endfunction

    wire acc_phase = psel & penable;
    wire wr_en = acc_phase & pwrite;
    wire sel_pwr = addr_hit(paddr, {`PMRC_IDX_PWR_MODE, 2'h0});
    wire sel_wake = addr_hit(paddr, `PMRC_OFF_WAKE_EN);
    wire sel_clk = addr_hit(paddr, `PMRC_OFF_CLK_CFG);
    wire sel_rcfg = addr_hit(paddr, `PMRC_OFF_RST_CFG);
    wire sel_stat = addr_hit(paddr, `PMRC_OFF_STATUS);
    wire sel_init = addr_hit(paddr, `PMRC_OFF_CPU_INIT);
    wire sel_any = sel_pwr | sel_wake | sel_clk | sel_rcfg | sel_stat | sel_init;
    // mode writes outside run are dropped: the core cannot issue them then anyway
    wire wr_pwr = wr_en & sel_pwr & (state_reg == PMRC_RUN);
    wire code_idle = pwdata[7:0] == `PMRC_CODE_IDLE;
    wire code_stop = pwdata[7:0] == `PMRC_CODE_STOP;
    // the counter bounds the wait should the interval timer never overflow
    wire stab_done = bit_overflow | (stab_cnt_reg >= stab_limit_reg);

    always_comb begin
        state_next = state_reg;
        power_mode_control_next = power_mode_control_reg;
        if (wr_pwr) begin
            power_mode_control_next = pwdata[7:0];
        end
        unique case (state_reg)
            PMRC_RUN: begin
                if (wr_pwr && code_idle) begin
                    state_next = PMRC_IDLE;
                end else if (wr_pwr && code_stop) begin
                    state_next = PMRC_STOP;
                end
            end
            PMRC_IDLE: begin
                if (any_wake) begin
                    state_next = PMRC_RUN;
                    power_mode_control_next = 8'h00;
                end
            end
            PMRC_STOP: begin
                if (any_wake) begin
                    state_next = PMRC_STAB;
                    power_mode_control_next = 8'h00;
                end
            end
            PMRC_STAB: begin
                if (stab_done) begin
                    state_next = PMRC_RUN;
                end
            end
        endcase
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (sel_pwr) begin
            rdata_next[7:0] = power_mode_control_reg;
        end
        if (sel_wake) begin
            rdata_next[NWAKE-1:0] = wake_enable_reg;
        end
        if (sel_clk) begin
            rdata_next[1:0] = clk_src_reg;
        end
        if (sel_rcfg) begin
            rdata_next[15:0] = stab_limit_reg;
        end
        if (sel_stat) begin
            rdata_next[1:0] = state_reg;
            rdata_next[12:8] = rst_flags_reg;
        end
        if (sel_init) begin
            rdata_next[1:0] = rst_cfg_reg;
        end
    end

    // any qualified reset re-initialises every control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= PMRC_RUN;
            power_mode_control_reg <= 8'h00;
        end else if (any_reset) begin
            state_reg <= PMRC_RUN;
            power_mode_control_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            power_mode_control_reg <= power_mode_control_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_enable_reg <= '0;
        end else if (any_reset) begin
            wake_enable_reg <= '0;
        end else if (wr_en & sel_wake) begin
            wake_enable_reg <= pwdata[NWAKE-1:0];
        end
    end

    // the clock source decides which oscillator stop may halt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_src_reg <= `PMRC_CLK_IRC;
        end else if (any_reset) begin
            clk_src_reg <= `PMRC_CLK_IRC;
        end else if (wr_en & sel_clk) begin
            clk_src_reg <= pwdata[1:0];
        end
    end

    // software must size this before stop, like the interval timer prescale
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_limit_reg <= `PMRC_STAB_DEF;
        end else if (any_reset) begin
            stab_limit_reg <= `PMRC_STAB_DEF;
        end else if (wr_en & sel_rcfg) begin
            stab_limit_reg <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cfg_reg <= 2'h0;
        end else if (any_reset) begin
            rst_cfg_reg <= 2'h0;
        end else if (wr_en & sel_init) begin
            rst_cfg_reg <= pwdata[1:0];
        end
    end

    // flags: a new reset source wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_flags_reg <= '0;
        end else begin
            rst_flags_reg <= (rst_flags_reg & ~((wr_en & sel_stat) ? pwdata[12:8] : 5'h00)) | rst_qual;
        end
    end

    // counts only while stabilising, so every wake starts from zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_cnt_reg <= 16'h0000;
        end else if (state_reg == PMRC_STAB) begin
            stab_cnt_reg <= stab_cnt_reg + 16'h0001;
        end else begin
            stab_cnt_reg <= 16'h0000;
        end
    end

    // apb: zero wait states; unmapped offsets read zero and flag pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= rdata_next;
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~sel_any;
        end
    end

    wire nx_run = state_next == PMRC_RUN;
    wire nx_stop = state_next == PMRC_STOP;
    wire nx_sleep = nx_stop | (state_next == PMRC_STAB);
    wire rst_any_nx = any_reset;

    // core-side halt and reset levels, and one-cycle strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_halt <= 1'b0;
            cpu_vector_req <= 1'b0;
            bit_start <= 1'b0;
            core_reset <= 1'b1;
        end else begin
            cpu_halt <= ~nx_run & ~rst_any_nx;
            cpu_vector_req <= any_wake & global_interrupt_enable &
                              ((state_reg == PMRC_IDLE) | (state_reg == PMRC_STOP));
            bit_start <= (state_reg == PMRC_STOP) & (state_next == PMRC_STAB);
            core_reset <= rst_any_nx;
        end
    end

    // system and peripheral clocks come back at once on any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
        end else begin
            sys_clk_en <= ~nx_sleep | rst_any_nx;
            periph_clk_en <= ~nx_sleep | rst_any_nx;
        end
    end

    // only the oscillator feeding the system clock stops; the others keep running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irc_osc_en <= 1'b1;
            main_osc_en <= 1'b1;
            sub_osc_en <= 1'b1;
        end else begin
            irc_osc_en <= ~(nx_stop & (clk_src_reg == `PMRC_CLK_IRC));
            main_osc_en <= ~(nx_stop & (clk_src_reg == `PMRC_CLK_MAIN));
            sub_osc_en <= ~(nx_stop & (clk_src_reg == `PMRC_CLK_SUB));
        end
    end

    // event counters and externally clocked serial units keep their clocks in stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_clk_en <= '1;
            serial_clk_en <= 2'h3;
        end else begin
            timer_clk_en <= nx_sleep ? timer_event_mode : {NTIMER{1'b1}};
            serial_clk_en <= nx_sleep ? serial_ext_clock : 2'h3;
        end
    end

    // start values are constants held in flops so every output stays registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_init <= `PMRC_PC_RESET;
            acc_init <= `PMRC_ACC_RESET;
            sp_init <= `PMRC_SP_RESET;
        end else begin
            pc_init <= `PMRC_PC_RESET;
            acc_init <= `PMRC_ACC_RESET;
            sp_init <= `PMRC_SP_RESET;
        end
    end
endmodule
`default_nettype wire

// ===== sim/pmrc_top_asserts.sv
/*
 pmrc_top_asserts: port-level properties of the power-mode controller.
 assumes it is bound into pmrc_top and that pclk is the only clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pmrc_top_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_halt,
    input wire logic bit_start,
    input wire logic sys_clk_en,
    input wire logic periph_clk_en,
    input wire logic core_reset
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a committed mode write while the core runs
    wire logic mode_wr = psel && penable && pready && pwrite && paddr == 12'h21c && !cpu_halt;

    property p_ready; pready |-> psel && penable; endproperty
    a_ready: assert property (p_ready) else $error("pready outside an access phase");
    property p_setup; psel && !penable |=> pready; endproperty
    a_setup: assert property (p_setup) else $error("setup not answered next cycle");
    property p_slverr; pready && paddr[11:8] == 4'h2 && paddr[7:0] != 8'h1c |-> pslverr; endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access without error");
    property p_clk_on; core_reset |=> periph_clk_en; endproperty
    a_clk_on: assert property (p_clk_on) else $error("peripheral clock off after reset");
    property p_stop; !sys_clk_en |-> !periph_clk_en && cpu_halt; endproperty
    a_stop: assert property (p_stop) else $error("stop with core or peripherals clocked");
    property p_idle; mode_wr && pwdata[7:0] == 8'h01 |-> ##[1:2] cpu_halt && periph_clk_en && sys_clk_en; endproperty
    a_idle: assert property (p_idle) else $error("idle code not honoured");
    property p_other; mode_wr && pwdata[7:0] != 8'h01 && pwdata[7:0] != 8'h03 |=> !cpu_halt [*3]; endproperty
    a_other: assert property (p_other) else $error("other code halted the core");
    property p_stab; bit_start |-> cpu_halt ##1 cpu_halt; endproperty
    a_stab: assert property (p_stab) else $error("core released before stabilisation");
endmodule
bind pmrc_top pmrc_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .cpu_halt(cpu_halt),
    .bit_start(bit_start), .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en), .core_reset(core_reset));
`default_nettype wire

// ===== sim/pmrc_cpu_model.sv
/*
 pmrc_cpu_model: interval timer beside the core, timing oscillator settling.
 assumes bit_start is a one-cycle pulse on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pmrc_cpu_model #(
    parameter int DLY = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bit_start,
    output logic bit_overflow
);
    int cnt;
    // prescale chosen before stop so the wait is long enough
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            bit_overflow <= 1'b0;
        end else begin
            bit_overflow <= (cnt == 1);
            cnt <= bit_start ? DLY : (cnt != 0 ? cnt - 1 : 0);
        end
    end
endmodule
`default_nettype wire

// ===== sim/power_mode_and_reset_control_test.sv
/*
 bench for pmrc_top: apb master, wake sources and reset pins driven here.
 assumes pmrc_cpu_model answers bit_start; clk source left at internal rc.
*/
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_reset_control_test import pmrc_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, global_interrupt_enable = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, v, seed = 90;
    logic err, external_reset_pin_n = 1, power_on_reset = 0, watchdog_overflow = 0, watchdog_enable_bit = 0;
    logic low_voltage_reset = 0, low_voltage_reset_control_bit = 1, debug_reset = 0;
    logic [6:0] irq_pending = 0;
    logic [4:0] timer_event_mode = 5'h01;
    logic [1:0] serial_ext_clock = 2'h1;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, cpu_halt, cpu_vector_req, bit_start, bit_overflow, sys_clk_en, periph_clk_en;
    wire logic irc_osc_en, main_osc_en, sub_osc_en, core_reset;
    wire logic [4:0] timer_clk_en;
    wire logic [1:0] serial_clk_en;
    wire logic [15:0] pc_init;
    wire logic [7:0] acc_init, sp_init;
    int mismatches = 0, cmp_count = 0, n, vec = 0, bst = 0, v0, b0, exp_pwr = 0;
    int exp_q[$];

    pmrc_top u_dut (.*);
    pmrc_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .bit_start(bit_start), .bit_overflow(bit_overflow));

    initial begin
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (cpu_vector_req === 1'b1) vec++;
        if (bit_start === 1'b1) bst++;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", s, e, g);
        end
    endtask
    // held unchanged until pready is sampled high; the idle edge first keeps
    // back-to-back calls from lowering and raising psel in one time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wait_run();
        n = 0;
        while (cpu_halt !== 1'b0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk("core running", 0, cpu_halt);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk("core init", 32'h00000007, {pc_init, acc_init, sp_init});
        apb(0, 12'h21c, 0);
        chk("mode reset", exp_pwr, rd);
        apb(0, 12'h200, 0);
        chk("unmapped", 1, err);
        for (int i = 0; i < 6; i++) begin
            v = xs() & 32'hff;
            if (v == 1 || v == 3) v = v + 32'h10;
            apb(1, 12'h21c, v);
            exp_q.push_back(v);
            apb(0, 12'h21c, 0);
            chk("mode rw", exp_q.pop_front(), rd);
            chk("no halt", 0, cpu_halt);
        end
        apb(1, 12'h21c, 0);
        apb(1, 12'h104, 0);
        apb(1, 12'h100, 32'h7f);
        $display("test codes done");
        for (int m = 1; m <= 3; m += 2) begin
            global_interrupt_enable <= (m == 1);
            apb(1, 12'h21c, m);
            repeat (3) @(posedge pclk);
            chk("halted", 1, cpu_halt);
            chk("sys clk", m == 1, sys_clk_en);
            chk("periph clk", m == 1, periph_clk_en);
            chk("rc osc", m == 1, irc_osc_en);
            chk("main osc", 1, main_osc_en);
            chk("sub osc", 1, sub_osc_en);
            chk("timers", m == 1 ? 5'h1f : 5'h01, timer_clk_en);
            chk("serial", m == 1 ? 2'h3 : 2'h1, serial_clk_en);
            v0 = vec;
            b0 = bst;
            v = xs() % 7;
            irq_pending[v[2:0]] <= 1;
            wait_run();
            irq_pending <= 0;
            @(posedge pclk);
            chk("vector", m == 1, vec - v0);
            chk("stab start", m == 3, bst - b0);
            apb(0, 12'h21c, 0);
            chk("mode cleared", 0, rd);
            $display("test mode %0d done", m);
        end
        apb(1, 12'h21c, 1);
        repeat (3) @(posedge pclk);
        debug_reset <= 1;
        repeat (3) @(posedge pclk);
        debug_reset <= 0;
        @(posedge pclk);
        chk("core reset", 1, core_reset);
        wait_run();
        apb(0, 12'h10c, 0);
        chk("debug flag", 32'h1000, rd & 32'h1f00);
        apb(1, 12'h10c, 32'h1f00);
        watchdog_overflow <= 1;
        repeat (3) @(posedge pclk);
        watchdog_overflow <= 0;
        repeat (5) @(posedge pclk);
        apb(0, 12'h10c, 0);
        chk("wdt gated", 0, rd & 32'h1f00);
        apb(0, 12'h21c, 0);
        chk("mode after reset", 0, rd);
        $display("test resets done");
        final_report();
    end
endmodule
`default_nettype wire
